//--- hdl/sbc_bank_ctrl.sv
// How it works
// - mode-register load takes the op-code from all twelve address bits
// - activate takes row from address and bank from bank inputs, opens row
// - read/write take column A0-A7, bank; A10 selects auto precharge once
// - precharge A10 low hits one bank; A10 high hits all banks
// - refresh code: auto with clock enable high, else self refresh
// - refresh row comes from internal counter; other inputs ignored
// - byte mask gates write data now, read drivers three clocks later
// - power-down exit with nop leaves all banks idle next edge
// - clock suspend exit resumes operation, next command taken next edge
// - clock enable falling picks power-down, self refresh or suspend
// - each bank tracks idle after tRP and active after tRCD
// - bank stays read/write until its burst ends or is cut
// - auto-precharge access keeps bank busy then returns idle alone
// - burst terminate stops the most recent burst of any bank unless it has auto precharge
// - precharge to an idle bank changes nothing
// - precharge cuts a burst; read/write replaces a running burst
// - masked read data pins go high impedance three clocks later
`timescale 1ns/10ps
`default_nettype none
`include "sbc_consts.svh"
module sbc_bank_ctrl #(
   parameter int DQ_W = 16,
   parameter int BURST_LEN = `SBC_BURST_LEN
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // command pins
   input wire logic i_cke,
   input wire sbc_pkg::sbc_pins_t i_pins,
   input wire logic [1:0] i_dqm,
   // data pins
   input wire logic [DQ_W-1:0] i_dq,
   output logic [DQ_W-1:0] o_dq,
   output logic [1:0] o_dq_oe_n,
   // array side: write stream through buffer
   output logic o_wr_valid,
   input wire logic i_wr_ready,
   output logic [DQ_W+9:0] o_wr_data,
   // array side: read data and column accesses
   input wire logic [DQ_W-1:0] i_rd_data,
   output sbc_pkg::sbc_access_t o_access,
   output logic o_access_valid,
   output logic [11:0] o_mode,
   output logic [11:0] o_ref_row,
   output logic o_ref_pulse,
   // status
   output logic [11:0] o_row [0:3],
   output sbc_pkg::sbc_bank_t o_bank_state [0:3],
   output sbc_pkg::sbc_dev_t o_dev_state,
   output logic o_wr_stall
);
   localparam int NB = `SBC_NUM_BANKS;
   localparam logic [`SBC_CNT_W-1:0] TRP = `SBC_CNT_W'(`SBC_TRP_CYC);
   localparam logic [`SBC_CNT_W-1:0] TRCD = `SBC_CNT_W'(`SBC_TRCD_CYC);
   localparam logic [`SBC_CNT_W-1:0] TRC = `SBC_CNT_W'(`SBC_TRC_CYC);
   localparam logic [`SBC_CNT_W-1:0] TMRD = `SBC_CNT_W'(`SBC_TMRD_CYC);
   localparam logic [`SBC_CNT_W-1:0] TXSR = `SBC_CNT_W'(`SBC_TXSR_CYC);
   localparam logic [`SBC_CNT_W-1:0] BLEN = `SBC_CNT_W'(BURST_LEN);

   function automatic sbc_pkg::sbc_cmd_t decode(input sbc_pkg::sbc_pins_t p);
      logic [2:0] c;
      c = {p.ras_n, p.cas_n, p.we_n};
      if (p.cs_n) begin
         decode = sbc_pkg::SBC_CMD_NOP;
      end else begin
         unique case (c)
            3'h7: decode = sbc_pkg::SBC_CMD_NOP;
            3'h3: decode = sbc_pkg::SBC_CMD_ACT;
            3'h5: decode = sbc_pkg::SBC_CMD_RD;
            3'h4: decode = sbc_pkg::SBC_CMD_WR;
            3'h6: decode = sbc_pkg::SBC_CMD_BST;
            3'h2: decode = sbc_pkg::SBC_CMD_PRE;
            3'h1: decode = sbc_pkg::SBC_CMD_REF;
            3'h0: decode = sbc_pkg::SBC_CMD_MRS;
         endcase
      end
   endfunction : decode

   function automatic logic burst_state(input sbc_pkg::sbc_bank_t s);
      burst_state = (s == sbc_pkg::SBC_B_READ) || (s == sbc_pkg::SBC_B_WRITE) ||
         (s == sbc_pkg::SBC_B_RDAP) || (s == sbc_pkg::SBC_B_WRAP);
   endfunction : burst_state

   // state
   sbc_pkg::sbc_bank_t bank [0:NB-1];
   sbc_pkg::sbc_bank_t next_bank [0:NB-1];
   logic [`SBC_CNT_W-1:0] bcnt [0:NB-1];
   logic [`SBC_CNT_W-1:0] next_bcnt [0:NB-1];
   logic [11:0] row [0:NB-1];
   logic [11:0] next_row [0:NB-1];
   sbc_pkg::sbc_dev_t dev, next_dev;
   logic [`SBC_CNT_W-1:0] dcnt, next_dcnt;
   logic cke_q, next_cke_q;
   logic [11:0] mode, next_mode, ref_row, next_ref_row;
   logic ref_pulse, next_ref_pulse;
   logic [1:0] last_bank, next_last_bank;
   logic [1:0] dqm_d1, dqm_d2, next_dqm_d1, next_dqm_d2;
   logic [DQ_W-1:0] dq_out, next_dq_out;
   logic rd_live, next_rd_live;
   logic [1:0] oe_n, next_oe_n;
   sbc_pkg::sbc_access_t acc, next_acc;
   logic acc_v, next_acc_v;
   sbc_pkg::sbc_cmd_t cmd;
   logic all_idle, any_rd, taking, buf_ready, wr_beat;

   always_comb begin
      cmd = decode(i_pins);
      all_idle = 1'b1;
      any_rd = 1'b0;
      wr_beat = 1'b0;
      for (int b = 0; b < NB; b++) begin
         if (bank[b] != sbc_pkg::SBC_B_IDLE) all_idle = 1'b0;
         if ((bank[b] == sbc_pkg::SBC_B_WRITE || bank[b] == sbc_pkg::SBC_B_WRAP) &&
             bcnt[b] > `SBC_CNT_W'(1)) begin
            wr_beat = 1'b1;
         end
         if (bank[b] == sbc_pkg::SBC_B_READ || bank[b] == sbc_pkg::SBC_B_RDAP) begin
            any_rd = 1'b1;
         end
      end
      // awake, cke high both edges
      taking = (dev == sbc_pkg::SBC_D_NORMAL) && cke_q && i_cke;
   end

   // device power modes and busy windows
   always_comb begin
      next_dev = dev;
      next_dcnt = (dcnt != '0) ? dcnt - `SBC_CNT_W'(1) : dcnt;
      next_cke_q = i_cke;
      next_mode = mode;
      next_ref_row = ref_row;
      next_ref_pulse = 1'b0;
      unique case (dev)
         sbc_pkg::SBC_D_NORMAL: begin
            if (cke_q && !i_cke) begin
               if (all_idle && cmd == sbc_pkg::SBC_CMD_REF) begin
                  next_dev = sbc_pkg::SBC_D_SELF;
               end else if (all_idle && cmd == sbc_pkg::SBC_CMD_NOP) begin
                  next_dev = sbc_pkg::SBC_D_PWRDN;
               end else if (!all_idle) begin
                  next_dev = sbc_pkg::SBC_D_SUSP;
               end
            end else if (taking && cmd == sbc_pkg::SBC_CMD_REF) begin
               // row from internal counter; address pins ignored
               next_ref_row = ref_row + 12'h001;
               next_ref_pulse = 1'b1;
               next_dev = sbc_pkg::SBC_D_BUSY;
               next_dcnt = TRC - `SBC_CNT_W'(1);
            end else if (taking && cmd == sbc_pkg::SBC_CMD_MRS) begin
               next_mode = i_pins.addr;
               next_dev = sbc_pkg::SBC_D_BUSY;
               next_dcnt = TMRD - `SBC_CNT_W'(1);
            end
         end
         // cke low keeps each mode; exit on a rising cke
         sbc_pkg::SBC_D_PWRDN: if (i_cke) next_dev = sbc_pkg::SBC_D_NORMAL;
         sbc_pkg::SBC_D_SUSP: if (i_cke) next_dev = sbc_pkg::SBC_D_NORMAL;
         sbc_pkg::SBC_D_SELF: begin
            if (i_cke) begin
               next_dev = sbc_pkg::SBC_D_XSR;
               next_dcnt = TXSR - `SBC_CNT_W'(1);
            end
         end
         // inputs ignored until the count runs out
         sbc_pkg::SBC_D_XSR, sbc_pkg::SBC_D_BUSY: begin
            if (dcnt == '0) next_dev = sbc_pkg::SBC_D_NORMAL;
         end
         default: next_dev = sbc_pkg::SBC_D_NORMAL;
      endcase
   end

   // per-bank state
   always_comb begin
      next_last_bank = last_bank;
      next_acc = acc;
      next_acc_v = 1'b0;
      for (int b = 0; b < NB; b++) begin
         next_bank[b] = bank[b];
         next_row[b] = row[b];
         next_bcnt[b] = (bcnt[b] != '0) ? bcnt[b] - `SBC_CNT_W'(1) : bcnt[b];
         // suspend freezes bursts
         if (dev == sbc_pkg::SBC_D_SUSP || (dev == sbc_pkg::SBC_D_NORMAL && !i_cke)) begin
            next_bcnt[b] = bcnt[b];
         end else if (bcnt[b] == `SBC_CNT_W'(1) || bcnt[b] == '0) begin
            unique case (bank[b])
               sbc_pkg::SBC_B_PRECH: next_bank[b] = sbc_pkg::SBC_B_IDLE;
               sbc_pkg::SBC_B_ACTING: next_bank[b] = sbc_pkg::SBC_B_ACTIVE;
               sbc_pkg::SBC_B_READ, sbc_pkg::SBC_B_WRITE: begin
                  next_bank[b] = sbc_pkg::SBC_B_ACTIVE;
               end
               sbc_pkg::SBC_B_RDAP, sbc_pkg::SBC_B_WRAP: begin
                  next_bank[b] = sbc_pkg::SBC_B_PRECH;
                  next_bcnt[b] = TRP - `SBC_CNT_W'(1);
               end
               default: next_bank[b] = bank[b];
            endcase
         end
      end
      if (taking) begin
         unique case (cmd)
            sbc_pkg::SBC_CMD_ACT: begin
               next_row[i_pins.ba] = i_pins.addr;
               next_bank[i_pins.ba] = sbc_pkg::SBC_B_ACTING;
               next_bcnt[i_pins.ba] = TRCD - `SBC_CNT_W'(1);
            end
            sbc_pkg::SBC_CMD_RD, sbc_pkg::SBC_CMD_WR: begin
               // new burst replaces old
               if (bank[i_pins.ba] == sbc_pkg::SBC_B_ACTIVE || burst_state(bank[i_pins.ba])) begin
                  if (cmd == sbc_pkg::SBC_CMD_RD) begin
                     next_bank[i_pins.ba] = i_pins.addr[`SBC_AP_BIT] ?
                        sbc_pkg::SBC_B_RDAP : sbc_pkg::SBC_B_READ;
                  end else begin
                     next_bank[i_pins.ba] = i_pins.addr[`SBC_AP_BIT] ?
                        sbc_pkg::SBC_B_WRAP : sbc_pkg::SBC_B_WRITE;
                  end
                  next_bcnt[i_pins.ba] = BLEN;
                  next_last_bank = i_pins.ba;
                  next_acc.ba = i_pins.ba;
                  next_acc.col = i_pins.addr[`SBC_COL_MSB:0];
                  next_acc.wr = (cmd == sbc_pkg::SBC_CMD_WR);
                  next_acc_v = 1'b1;
               end
            end
            sbc_pkg::SBC_CMD_BST: begin
               if (bank[last_bank] == sbc_pkg::SBC_B_READ ||
                   bank[last_bank] == sbc_pkg::SBC_B_WRITE) begin
                  next_bank[last_bank] = sbc_pkg::SBC_B_ACTIVE;
                  next_bcnt[last_bank] = '0;
               end
            end
            sbc_pkg::SBC_CMD_PRE: begin
               for (int b = 0; b < NB; b++) begin
                  if ((i_pins.addr[`SBC_AP_BIT] || i_pins.ba == 2'(b)) &&
                      bank[b] != sbc_pkg::SBC_B_IDLE) begin
                     next_bank[b] = sbc_pkg::SBC_B_PRECH;
                     next_bcnt[b] = TRP - `SBC_CNT_W'(1);
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // read drivers follow dqm three clocks late
   always_comb begin
      next_dqm_d1 = i_dqm;
      next_dqm_d2 = dqm_d1;
      next_rd_live = any_rd;
      next_dq_out = i_rd_data;
      next_oe_n = 2'h3;
      if (rd_live) begin
         next_oe_n = dqm_d2;
      end
   end

   // write data with mask enters the buffer same cycle
   sbc_skid #(
      .WIDTH(DQ_W + 10)
   ) u_wbuf (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_valid(taking && (cmd == sbc_pkg::SBC_CMD_WR || wr_beat) && i_dqm != 2'h3),
      .o_ready(buf_ready),
      .i_data({i_dqm, i_dq & {{(DQ_W/2){~i_dqm[1]}}, {(DQ_W/2){~i_dqm[0]}}},
         i_pins.addr[`SBC_COL_MSB:0]}),
      .o_valid(o_wr_valid),
      .i_ready(i_wr_ready),
      .o_data(o_wr_data)
   );

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int b = 0; b < NB; b++) begin
            bank[b] <= sbc_pkg::SBC_B_IDLE;
            bcnt[b] <= '0;
            row[b] <= '0;
         end
         dev <= sbc_pkg::SBC_D_NORMAL;
         dcnt <= '0;
         cke_q <= 1'b0;
         mode <= '0;
         ref_row <= '0;
         ref_pulse <= 1'b0;
         last_bank <= 2'h0;
         dqm_d1 <= 2'h3;
         dqm_d2 <= 2'h3;
         rd_live <= 1'b0;
         dq_out <= '0;
         oe_n <= 2'h3;
         acc <= '0;
         acc_v <= 1'b0;
      end else begin
         for (int b = 0; b < NB; b++) begin
            bank[b] <= next_bank[b];
            bcnt[b] <= next_bcnt[b];
            row[b] <= next_row[b];
         end
         dev <= next_dev;
         dcnt <= next_dcnt;
         cke_q <= next_cke_q;
         mode <= next_mode;
         ref_row <= next_ref_row;
         ref_pulse <= next_ref_pulse;
         last_bank <= next_last_bank;
         dqm_d1 <= next_dqm_d1;
         dqm_d2 <= next_dqm_d2;
         rd_live <= next_rd_live;
         dq_out <= next_dq_out;
         oe_n <= next_oe_n;
         acc <= next_acc;
         acc_v <= next_acc_v;
      end
   end

   // a full buffer is flagged, not stalled: the pins cannot wait
   assign o_wr_stall = !buf_ready;
   assign o_dq = dq_out;
   assign o_dq_oe_n = oe_n;
   assign o_access = acc;
   assign o_access_valid = acc_v;
   assign o_mode = mode;
   assign o_ref_row = ref_row;
   assign o_ref_pulse = ref_pulse;
   assign o_dev_state = dev;
   always_comb begin
      for (int b = 0; b < NB; b++) begin
         o_row[b] = row[b];
         o_bank_state[b] = bank[b];
      end
   end
endmodule : sbc_bank_ctrl
`default_nettype wire

//--- hdl/sbc_consts.svh
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH
// timing in ns, cycles derived at 10 ns clock
`define SBC_CLK_NS 10
`define SBC_TRP_NS 20
`define SBC_TRCD_NS 20
`define SBC_TRC_NS 70
`define SBC_TMRD_NS 20
`define SBC_TXSR_NS 70
`define SBC_CYC_UP(ns) (((ns) + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
`define SBC_TRP_CYC `SBC_CYC_UP(`SBC_TRP_NS)
`define SBC_TRCD_CYC `SBC_CYC_UP(`SBC_TRCD_NS)
`define SBC_TRC_CYC `SBC_CYC_UP(`SBC_TRC_NS)
`define SBC_TMRD_CYC `SBC_CYC_UP(`SBC_TMRD_NS)
`define SBC_TXSR_CYC `SBC_CYC_UP(`SBC_TXSR_NS)
// address field positions and other sizes
`define SBC_AP_BIT 10
`define SBC_COL_MSB 7
`define SBC_DQM_DELAY 2
`define SBC_NUM_BANKS 4
`define SBC_BURST_LEN 4
`define SBC_CNT_W 4
`endif

//--- hdl/sbc_pkg.sv
package sbc_pkg;
   typedef enum logic [2:0] {
      SBC_CMD_NOP, SBC_CMD_ACT, SBC_CMD_RD, SBC_CMD_WR,
      SBC_CMD_BST, SBC_CMD_PRE, SBC_CMD_REF, SBC_CMD_MRS
   } sbc_cmd_t;
   typedef enum logic [2:0] {
      SBC_B_IDLE, SBC_B_ACTING, SBC_B_ACTIVE, SBC_B_READ, SBC_B_WRITE,
      SBC_B_RDAP, SBC_B_WRAP, SBC_B_PRECH
   } sbc_bank_t;
   typedef enum logic [2:0] {
      SBC_D_NORMAL, SBC_D_PWRDN, SBC_D_SELF, SBC_D_SUSP, SBC_D_XSR, SBC_D_BUSY
   } sbc_dev_t;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [1:0] ba;
      logic [11:0] addr;
   } sbc_pins_t;
   typedef struct packed {
      logic [1:0] ba;
      logic [7:0] col;
      logic wr;
   } sbc_access_t;
endpackage : sbc_pkg

//--- hdl/sbc_skid.sv
`timescale 1ns/10ps
`default_nettype none
module sbc_skid #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // fill side
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   // drain side
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   logic [WIDTH-1:0] mem [0:1];
   logic [WIDTH-1:0] next_mem [0:1];
   logic [1:0] cnt, next_cnt;
   logic rd, next_rd, wr_ptr, next_wr_ptr;
   logic push, pop;
   // two entries; a word offered while both are full is lost
   always_comb begin
      push = i_valid && (cnt != 2'h2);
      pop = (cnt != 2'h0) && i_ready;
      next_mem[0] = mem[0];
      next_mem[1] = mem[1];
      if (push) begin
         next_mem[wr_ptr] = i_data;
      end
      next_wr_ptr = push ? ~wr_ptr : wr_ptr;
      next_rd = pop ? ~rd : rd;
      next_cnt = cnt + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mem[0] <= '0;
         mem[1] <= '0;
         cnt <= 2'h0;
         rd <= 1'b0;
         wr_ptr <= 1'b0;
      end else begin
         mem[0] <= next_mem[0];
         mem[1] <= next_mem[1];
         cnt <= next_cnt;
         rd <= next_rd;
         wr_ptr <= next_wr_ptr;
      end
   end
   assign o_ready = (cnt != 2'h2);
   assign o_valid = (cnt != 2'h0);
   assign o_data = mem[rd];
endmodule : sbc_skid
`default_nettype wire

//--- dv/sbc_chk_props.sv
`timescale 1ns/10ps
`default_nettype none
module sbc_chk (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // command pins
   input wire logic i_cke,
   input wire sbc_pkg::sbc_pins_t i_pins,
   input wire logic [1:0] i_dqm,
   // status
   input wire logic [1:0] o_dq_oe_n,
   input wire sbc_pkg::sbc_access_t o_access,
   input wire logic o_access_valid,
   input wire logic [11:0] o_mode,
   input wire logic [11:0] o_row [0:3],
   input wire sbc_pkg::sbc_bank_t o_bank_state [0:3],
   input wire sbc_pkg::sbc_dev_t o_dev_state
);
   logic [1:0] ba_q, lastb;
   logic [2:0] op;
   logic cke_q, live, idle4, quiet, rd0, ap0;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cke_q <= 1'b0;
         ba_q <= 2'h0;
         lastb <= 2'h0;
      end else begin
         cke_q <= i_cke;
         ba_q <= i_pins.ba;
         if (live && op[2:1] == 2'h2) begin
            lastb <= i_pins.ba;
         end
      end
   end
   always_comb begin
      op = {i_pins.ras_n, i_pins.cas_n, i_pins.we_n};
      live = o_dev_state == sbc_pkg::SBC_D_NORMAL && cke_q && i_cke && !i_pins.cs_n;
      idle4 = 1'b1;
      quiet = 1'b1;
      for (int b = 0; b < 4; b++) begin
         idle4 &= o_bank_state[b] == sbc_pkg::SBC_B_IDLE;
         quiet &= o_bank_state[b] inside {sbc_pkg::SBC_B_IDLE, sbc_pkg::SBC_B_PRECH};
      end
      rd0 = o_bank_state[0] == sbc_pkg::SBC_B_READ;
      ap0 = o_bank_state[0] inside {sbc_pkg::SBC_B_RDAP, sbc_pkg::SBC_B_WRAP};
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   mode_load_a: assert property (live && op == 3'h0 && idle4 |=>
      o_mode == $past(i_pins.addr)) else $error("mode not loaded");
   act_row_a: assert property (live && op == 3'h3 && o_bank_state[i_pins.ba] ==
      sbc_pkg::SBC_B_IDLE |=> o_bank_state[ba_q] == sbc_pkg::SBC_B_ACTING
      && o_row[ba_q] == $past(i_pins.addr)) else $error("row not opened");
   acc_addr_a: assert property (live && op[2:1] == 2'h2 && o_bank_state[i_pins.ba] ==
      sbc_pkg::SBC_B_ACTIVE |=> o_access_valid && o_access ==
      {$past(i_pins.ba), $past(i_pins.addr[7:0]), !$past(i_pins.we_n)})
      else $error("access fields wrong");
   ap_pick_a: assert property (live && op[2:1] == 2'h2 && o_bank_state[i_pins.ba] ==
      sbc_pkg::SBC_B_ACTIVE |=> ($past(i_pins.addr[10]) == (o_bank_state[ba_q] inside
      {sbc_pkg::SBC_B_RDAP, sbc_pkg::SBC_B_WRAP}))) else $error("auto precharge pick");
   pre_all_a: assert property (live && op == 3'h2 && i_pins.addr[10] |=> quiet)
      else $error("bank left open");
   pre_idle_a: assert property (live && op == 3'h2 && !i_pins.addr[10] &&
      o_bank_state[i_pins.ba] == sbc_pkg::SBC_B_IDLE |=> o_bank_state[ba_q] ==
      sbc_pkg::SBC_B_IDLE) else $error("idle bank disturbed");
   bst_stop_a: assert property (live && op == 3'h6 && o_bank_state[lastb] ==
      sbc_pkg::SBC_B_READ |=> o_bank_state[lastb] == sbc_pkg::SBC_B_ACTIVE)
      else $error("burst not stopped");
   self_in_a: assert property (o_dev_state == sbc_pkg::SBC_D_NORMAL && cke_q &&
      !i_cke && !i_pins.cs_n && op == 3'h1 && idle4 |=> o_dev_state == sbc_pkg::SBC_D_SELF)
      else $error("no self refresh");
   pd_exit_a: assert property (o_dev_state == sbc_pkg::SBC_D_PWRDN && i_cke &&
      (i_pins.cs_n || op == 3'h7) |=> o_dev_state == sbc_pkg::SBC_D_NORMAL)
      else $error("power-down exit late");
   susp_exit_a: assert property (o_dev_state == sbc_pkg::SBC_D_SUSP && i_cke |=>
      o_dev_state == sbc_pkg::SBC_D_NORMAL) else $error("suspend exit late");
   low_keep_a: assert property (!i_cke && o_dev_state inside {sbc_pkg::SBC_D_PWRDN,
      sbc_pkg::SBC_D_SELF, sbc_pkg::SBC_D_SUSP} |=> $stable(o_dev_state))
      else $error("low state not kept");
   ap_done_a: assert property ($rose(ap0) |-> ##[4:9] o_bank_state[0] ==
      sbc_pkg::SBC_B_IDLE) else $error("ap stuck");
   oe_mask_a: assert property (rd0 && $past(rd0) && $past(rd0, 2) && $past(rd0, 3) |->
      o_dq_oe_n == $past(i_dqm, 3)) else $error("read mask delay");
   cover property (live && op == 3'h1);
   cover property (o_dev_state == sbc_pkg::SBC_D_SUSP);
   cover property (o_dev_state == sbc_pkg::SBC_D_XSR);
endmodule : sbc_chk
bind sbc_bank_ctrl sbc_chk u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cke(i_cke),
   .i_pins(i_pins), .i_dqm(i_dqm), .o_dq_oe_n(o_dq_oe_n), .o_access(o_access),
   .o_access_valid(o_access_valid), .o_mode(o_mode), .o_row(o_row),
   .o_bank_state(o_bank_state), .o_dev_state(o_dev_state));
`default_nettype wire

//--- dv/sbc_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module sbc_ctrl_model (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // request
   input wire logic i_sel,
   input wire sbc_pkg::sbc_cmd_t i_cmd,
   input wire logic [1:0] i_ba,
   input wire logic [11:0] i_addr,
   // command pins
   output sbc_pkg::sbc_pins_t o_pins
);
   localparam logic [2:0] ENC [8] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h6, 3'h2, 3'h1, 3'h0};
   logic [15:0] junk;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         junk <= 16'h5a5a;
      end else begin
         junk <= {junk[14:0], ~junk[15]};
      end
   end
   always_comb begin
      o_pins = {1'b1, junk[2:0], junk[15:14], junk[11:0]};
      if (i_sel) begin
         o_pins = {1'b0, ENC[i_cmd], i_ba, i_addr};
      end
   end
endmodule : sbc_ctrl_model
`default_nettype wire

//--- dv/sbc_bank_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbc_consts.svh"
module sbc_bank_ctrl_tb_top;
   localparam int BL = `SBC_BURST_LEN;
   localparam int TRP = `SBC_TRP_CYC;
   localparam int TRCD = `SBC_TRCD_CYC;
   logic clk = 1'b0;
   logic arst_n, cke, sel, wr_ready, wr_valid, acc_v, stall, rnd, stall_seen;
   sbc_pkg::sbc_cmd_t cmd;
   logic [1:0] ba, dqm;
   logic [11:0] addr, mode, ref_row;
   logic [15:0] dq, rd_data;
   logic [25:0] wr_data;
   logic [11:0] row [0:3];
   sbc_pkg::sbc_bank_t bst [0:3];
   sbc_pkg::sbc_dev_t dev;
   sbc_pkg::sbc_pins_t pins;
   sbc_pkg::sbc_access_t access, acc;
   logic [25:0] got_q[$], exp_q[$];
   integer seed = 32'h0d3d;
   int err_count, n_tests, cyc;
   sbc_bank_ctrl u_sbc_bank_ctrl (.i_clk(clk), .i_arst_n(arst_n), .i_cke(cke), .i_pins(pins),
      .i_dqm(dqm), .i_dq(dq), .o_dq(), .o_dq_oe_n(), .o_wr_valid(wr_valid),
      .i_wr_ready(wr_ready), .o_wr_data(wr_data), .i_rd_data(rd_data), .o_access(access),
      .o_access_valid(acc_v), .o_mode(mode), .o_ref_row(ref_row), .o_ref_pulse(),
      .o_row(row), .o_bank_state(bst), .o_dev_state(dev), .o_wr_stall(stall));
   sbc_ctrl_model u_sbc_ctrl_model (.i_clk(clk), .i_arst_n(arst_n), .i_sel(sel),
      .i_cmd(cmd), .i_ba(ba), .i_addr(addr), .o_pins(pins));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      rd_data <= $random(seed);
      if (rnd) begin
         wr_ready <= $random(seed);
         dqm <= $random(seed);
      end
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
   end
   always @(negedge clk) begin
      if (acc_v) acc = access;
      if (wr_valid && wr_ready) got_q.push_back(wr_data);
      if (stall) stall_seen = 1'b1;
   end
   task finish_test;
      if (err_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task bank(input int b, input sbc_pkg::sbc_bank_t e);
      chk("bank", e, bst[b]);
   endtask : bank
   task put(input sbc_pkg::sbc_cmd_t c, input logic [1:0] b, input logic [11:0] a);
      @(posedge clk);
      sel <= 1'b1;
      cmd <= c;
      ba <= b;
      addr <= a;
   endtask : put
   task nop(input int n);
      @(posedge clk);
      sel <= 1'b0;
      repeat (n - 1) @(posedge clk);
      @(negedge clk);
   endtask : nop
   function logic [11:0] col(input logic ap);
      logic [11:0] r;
      r = $random(seed);
      col = {r[11], ap, r[9:0]};
   endfunction : col
   function logic [25:0] wmask(input logic [1:0] m);
      wmask = {2'h3, {8{!m[1]}}, {8{!m[0]}}, 8'h00};
   endfunction : wmask
   task wr(input logic [7:0] pat);
      logic [15:0] d;
      for (int i = 0; i < BL; i++) begin
         @(posedge clk);
         sel <= (i == 0);
         cmd <= sbc_pkg::SBC_CMD_WR;
         ba <= 2'h0;
         addr <= 12'h010;
         d = $random(seed);
         dq <= d;
         dqm <= pat[2*i+:2];
         if (pat[2*i+:2] != 2'h3) exp_q.push_back({pat[2*i+:2], d, 8'h00} & wmask(pat[2*i+:2]));
      end
   endtask : wr
   initial begin
      logic [11:0] a, md, r0;
      logic [1:0] b;
      logic w;
      {sel, cke, dqm, dq, wr_ready, rd_data, rnd, stall_seen, ba, addr} = '0;
      arst_n = 1'b0;
      cmd = sbc_pkg::SBC_CMD_NOP;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      cke <= 1'b1;
      nop(3);
      md = $random(seed);
      put(sbc_pkg::SBC_CMD_MRS, 2'h0, md);
      nop(`SBC_TMRD_CYC + 1);
      chk("mode", md, mode);
      for (int i = 0; i < 4; i++) begin
         a = $random(seed);
         put(sbc_pkg::SBC_CMD_ACT, i, a);
         nop(1);
         bank(i, sbc_pkg::SBC_B_ACTING);
         nop(TRCD);
         bank(i, sbc_pkg::SBC_B_ACTIVE);
         chk("row", a, row[i]);
      end
      rnd = 1'b1;
      for (int i = 0; i < 4; i++) begin
         a = col(1'b0);
         put(sbc_pkg::SBC_CMD_RD, i, a);
         nop(1);
         bank(i, sbc_pkg::SBC_B_READ);
         nop(2);
         chk("acc", {i[1:0], a[7:0], 1'b0}, acc);
         nop(BL);
         bank(i, sbc_pkg::SBC_B_ACTIVE);
      end
      put(sbc_pkg::SBC_CMD_RD, 2'h1, col(1'b0));
      put(sbc_pkg::SBC_CMD_BST, 2'h0, 12'h000);
      nop(1);
      bank(1, sbc_pkg::SBC_B_ACTIVE);
      a = col(1'b0);
      put(sbc_pkg::SBC_CMD_RD, 2'h2, col(1'b0));
      put(sbc_pkg::SBC_CMD_RD, 2'h2, a);
      nop(2);
      chk("acc", {2'h2, a[7:0], 1'b0}, acc);
      put(sbc_pkg::SBC_CMD_PRE, 2'h2, 12'h000);
      nop(1);
      bank(2, sbc_pkg::SBC_B_PRECH);
      nop(TRP);
      bank(2, sbc_pkg::SBC_B_IDLE);
      put(sbc_pkg::SBC_CMD_PRE, 2'h2, 12'h000);
      nop(1);
      bank(2, sbc_pkg::SBC_B_IDLE);
      rnd = 1'b0;
      wr_ready <= 1'b0;
      wr(8'h00);
      nop(3);
      chk("stall", 1, stall_seen);
      wr_ready <= 1'b1;
      nop(8);
      chk("drain", 0, wr_valid);
      got_q.delete();
      exp_q.delete();
      wr(8'b10_11_01_00);
      nop(6);
      chk("nwords", exp_q.size(), got_q.size());
      foreach (exp_q[i]) chk("wdata", exp_q[i], {got_q[i][25:8], 8'h00});
      put(sbc_pkg::SBC_CMD_RD, 2'h0, col(1'b1));
      nop(1);
      bank(0, sbc_pkg::SBC_B_RDAP);
      nop(BL + TRP + 2);
      bank(0, sbc_pkg::SBC_B_IDLE);
      put(sbc_pkg::SBC_CMD_WR, 2'h3, col(1'b1));
      nop(1);
      bank(3, sbc_pkg::SBC_B_WRAP);
      nop(BL + TRP + 2);
      bank(3, sbc_pkg::SBC_B_IDLE);
      put(sbc_pkg::SBC_CMD_ACT, 2'h2, 12'h000);
      nop(TRCD + 1);
      put(sbc_pkg::SBC_CMD_PRE, 2'h1, 12'h000);
      nop(1);
      bank(1, sbc_pkg::SBC_B_PRECH);
      bank(2, sbc_pkg::SBC_B_ACTIVE);
      nop(TRP);
      put(sbc_pkg::SBC_CMD_PRE, $random(seed), 12'h400);
      nop(1);
      bank(2, sbc_pkg::SBC_B_PRECH);
      nop(TRP);
      for (int i = 0; i < 4; i++) bank(i, sbc_pkg::SBC_B_IDLE);
      r0 = ref_row;
      put(sbc_pkg::SBC_CMD_REF, $random(seed), $random(seed));
      nop(`SBC_TRC_CYC + 1);
      chk("refrow", r0 + 12'h001, ref_row);
      chk("mode", md, mode);
      bank(1, sbc_pkg::SBC_B_IDLE);
      @(posedge clk);
      cke <= 1'b0;
      nop(3);
      chk("dev", sbc_pkg::SBC_D_PWRDN, dev);
      @(posedge clk);
      cke <= 1'b1;
      nop(1);
      chk("dev", sbc_pkg::SBC_D_NORMAL, dev);
      put(sbc_pkg::SBC_CMD_REF, 2'h0, 12'h000);
      cke <= 1'b0;
      nop(4);
      chk("dev", sbc_pkg::SBC_D_SELF, dev);
      @(posedge clk);
      cke <= 1'b1;
      nop(`SBC_TXSR_CYC + 1);
      chk("dev", sbc_pkg::SBC_D_NORMAL, dev);
      put(sbc_pkg::SBC_CMD_ACT, 2'h1, 12'h000);
      nop(TRCD + 1);
      put(sbc_pkg::SBC_CMD_RD, 2'h1, col(1'b0));
      @(posedge clk);
      sel <= 1'b0;
      cke <= 1'b0;
      nop(3);
      chk("dev", sbc_pkg::SBC_D_SUSP, dev);
      bank(1, sbc_pkg::SBC_B_READ);
      @(posedge clk);
      cke <= 1'b1;
      put(sbc_pkg::SBC_CMD_PRE, 2'h1, 12'h000);
      nop(1);
      bank(1, sbc_pkg::SBC_B_PRECH);
      nop(TRP);
      for (int i = 0; i < 4; i++) begin
         put(sbc_pkg::SBC_CMD_ACT, i, 12'h000);
         nop(TRCD + 1);
      end
      rnd = 1'b1;
      repeat (40) begin
         b = $random(seed);
         w = $random(seed);
         a = col(1'b0);
         put(w ? sbc_pkg::SBC_CMD_WR : sbc_pkg::SBC_CMD_RD, b, a);
         nop(2);
         chk("acc", {b, a[7:0], w}, acc);
         nop(BL);
      end
      finish_test();
   end
endmodule : sbc_bank_ctrl_tb_top
`default_nettype wire
